// *** verilog/ssc_pkg.sv ***
package ssc_pkg;
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned CONV_NS_8CH    = 4000;
  localparam int unsigned CONV_NS_6CH    = 3000;
  localparam int unsigned CONV_NS_4CH    = 2000;
  localparam int unsigned CH_MAX         = 8;
  localparam int unsigned RES_BITS       = 16;
  localparam int unsigned LSB_DIV        = 65536;
  localparam int unsigned SPAN_HI_MV     = 20000;
  localparam int unsigned SPAN_LO_MV     = 10000;
  localparam logic [15:0] RESULT_RST     = 16'h0000;
  localparam int unsigned CNT_W          = 8;

  function automatic int unsigned conv_cycles(input int unsigned chans);
    int unsigned ns;
    ns = (chans == 8) ? CONV_NS_8CH : (chans == 6) ? CONV_NS_6CH : CONV_NS_4CH;
    return (ns * CLK_MHZ) / 1000;
  endfunction

  typedef enum logic [1:0] {SSC_IDLE, SSC_ARMED, SSC_CONV} ssc_state_e;

  typedef struct packed {
    logic       range_hi;
    logic       int_ref_en;
  } ssc_cfg_s;
endpackage

// *** verilog/ssc_result_mem.sv ***
`timescale 1ns/1ns
module ssc_result_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned W     = 16
) (
  input  wire logic                     clock_in,   // clock
  input  wire logic                     wr_in,      // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr_in,   // write address
  input  wire logic [W-1:0]             wdata_in,   // write data
  input  wire logic [$clog2(DEPTH)-1:0] raddr_in,   // read address
  output logic      [W-1:0]             rdata_out   // registered read data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clock_in) begin
    if (wr_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule

// *** verilog/ssc_conv_ctrl.sv ***
`timescale 1ns/1ns
module ssc_conv_ctrl
  import ssc_pkg::*;
#(
  parameter int unsigned CHANNELS = 8
) (
  input  wire logic                 clock_in,                // 25 MHz clock
  input  wire logic                 rst_b_in,                // async reset, low active
  input  wire logic                 first_set_start_pulse_in,  // start, first set (pin)
  input  wire logic                 second_set_start_pulse_in, // start, second set (pin)
  input  wire logic                 range_pin_in,            // 1: 20 V span, 0: 10 V
  input  wire logic                 ref_select_in,           // 1: internal reference
  input  wire logic signed [15:0]   sample_in,               // code from SAR core
  input  wire logic [2:0]           rd_addr_in,              // result channel to read
  output logic [15:0]               rd_data_out,             // result, twos complement
  output logic                      busy_out,                // conversion in progress
  output logic [1:0]                hold_out,                // per-set hold (1 = hold)
  output logic [2:0]                conv_ch_out,             // channel being converted
  output ssc_pkg::ssc_cfg_s         cfg_out,                 // live range/reference
  output logic                      reference_io_pin_oe_b_out, // low: drive ref pin
  output logic [15:0]               lsb_uv_out               // LSB weight in microvolts
);
  import ssc_pkg::*;

  localparam int unsigned CYC   = conv_cycles(CHANNELS);
  localparam int unsigned PER_CH = CYC / CHANNELS;
  // the last slot takes the remainder so busy spans the full conversion time
  localparam int unsigned LAST_SLOT = CYC - PER_CH * (CHANNELS - 1);

  logic [1:0] sa_reg, sb_reg, sc_reg;
  logic [1:0] last_reg;
  logic       a_rise, b_rise;
  ssc_state_e st_reg, st_next;
  logic [1:0] hold_reg, hold_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] ch_reg, ch_next;
  logic       wr;
  ssc_cfg_s   cfg_reg, cfg_next;
  logic       cfg_take_reg;
  logic [CNT_W-1:0] slot_end;

  assign slot_end = (ch_reg == 3'(CHANNELS - 1)) ? CNT_W'(LAST_SLOT - 1)
                                                 : CNT_W'(PER_CH - 1);

  // two-stage synchronisers for start pins and straps
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sa_reg   <= 2'h0;
      sb_reg   <= 2'h0;
      sc_reg   <= 2'h0;
      last_reg <= 2'h0;
    end else begin
      sa_reg   <= {sa_reg[0], first_set_start_pulse_in};
      sb_reg   <= {sb_reg[0], second_set_start_pulse_in};
      sc_reg   <= {sc_reg[0], range_pin_in};
      last_reg <= {sb_reg[1], sa_reg[1]};
    end
  end

  assign a_rise = sa_reg[1] & ~last_reg[0];
  assign b_rise = sb_reg[1] & ~last_reg[1];

  logic [1:0] rs_reg;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rs_reg <= 2'h0;
    end else begin
      rs_reg <= {rs_reg[0], ref_select_in};
    end
  end

  // configuration follows pins, first taken right after reset release
  always_comb begin
    cfg_next.range_hi   = sc_reg[1];
    cfg_next.int_ref_en = rs_reg[1];
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_reg      <= '0;
      cfg_take_reg <= 1'b0;
    end else begin
      cfg_reg      <= cfg_next;
      cfg_take_reg <= 1'b1;
    end
  end

  always_comb begin
    st_next   = st_reg;
    hold_next = hold_reg;
    cnt_next  = cnt_reg;
    ch_next   = ch_reg;
    wr        = 1'b0;
    case (st_reg)
      SSC_IDLE, SSC_ARMED: begin
        hold_next = hold_reg | {b_rise, a_rise};
        if (&hold_next) begin
          st_next  = SSC_CONV;
          cnt_next = '0;
          ch_next  = '0;
        end else if (|hold_next) begin
          st_next = SSC_ARMED;
        end
      end
      SSC_CONV: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == slot_end) begin
          cnt_next = '0;
          wr       = 1'b1;
          ch_next  = ch_reg + 1'b1;
          if (ch_reg == 3'(CHANNELS - 1)) begin
            st_next   = SSC_IDLE;
            hold_next = 2'h0;
          end
        end
      end
      default: begin
        st_next   = SSC_IDLE;
        hold_next = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg   <= SSC_IDLE;
      hold_reg <= 2'h0;
      cnt_reg  <= '0;
      ch_reg   <= '0;
    end else begin
      st_reg   <= st_next;
      hold_reg <= hold_next;
      cnt_reg  <= cnt_next;
      ch_reg   <= ch_next;
    end
  end

  assign busy_out    = (st_reg == SSC_CONV);
  assign hold_out    = hold_reg;
  assign conv_ch_out = ch_reg;
  assign cfg_out     = cfg_reg;
  assign reference_io_pin_oe_b_out = ~(cfg_reg.int_ref_en & cfg_take_reg);

  // staging buffer written during conversion, committed at busy fall
  logic [15:0] stage [CH_MAX];
  logic [15:0] mem_wdata;
  logic [2:0]  commit_ch_reg;
  logic        commit_reg;
  logic        done;

  assign done = wr && (ch_reg == 3'(CHANNELS - 1));

  always_ff @(posedge clock_in) begin
    if (wr) begin
      stage[ch_reg] <= sample_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      commit_reg    <= 1'b0;
      commit_ch_reg <= 3'h0;
    end else if (done) begin
      commit_reg    <= 1'b1;
      commit_ch_reg <= 3'h0;
    end else if (commit_reg) begin
      commit_ch_reg <= commit_ch_reg + 1'b1;
      commit_reg    <= (commit_ch_reg != 3'(CHANNELS - 1));
    end
  end

  assign mem_wdata = stage[commit_ch_reg];

  // output register keeps previous results readable while busy
  ssc_result_mem #(.DEPTH(CH_MAX), .W(RES_BITS)) u_mem (
    .clock_in  (clock_in),
    .wr_in     (commit_reg),
    .waddr_in  (commit_ch_reg),
    .wdata_in  (mem_wdata),
    .raddr_in  (rd_addr_in),
    .rdata_out (rd_data_out)
  );

  // lsb weight: span / 65536, in microvolts (305 or 152)
  logic [31:0] lsb_full;
  assign lsb_full = (cfg_reg.range_hi ? 32'(SPAN_HI_MV) : 32'(SPAN_LO_MV)) * 32'd1000
                    / 32'(LSB_DIV);
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lsb_uv_out <= 16'h0000;
    end else begin
      lsb_uv_out <= lsb_full[15:0];
    end
  end

  // cycles spent busy, cleared by reset so an aborted run is not measured
  logic [CNT_W-1:0] busy_len_reg, busy_len_next;

  always_comb begin
    busy_len_next = busy_out ? busy_len_reg + 1'b1 : '0;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_len_reg <= '0;
    end else begin
      busy_len_reg <= busy_len_next;
    end
  end

  sequence s_later_edge;
    $past(a_rise || b_rise) && hold_out == 2'h3;
  endsequence

  a_busy_len: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ($fell(busy_out) && busy_len_reg != '0) |-> busy_len_reg == CNT_W'(CYC))
    else $error("busy length differs from conversion time");
  a_busy_cap: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    busy_out |-> busy_len_reg < CNT_W'(CYC))
    else $error("busy held beyond conversion time");
  a_busy_both: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    $rose(busy_out) |-> s_later_edge)
    else $error("busy rose without a start edge and both sets held");
  a_hold_busy: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    $fell(busy_out) |-> hold_out == 2'h0)
    else $error("holds not released at busy fall");
  a_hold_in_conv: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    busy_out |-> hold_out == 2'h3)
    else $error("a set left tracking during conversion");
  a_a_rise_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (a_rise && !busy_out) |=> hold_out[0])
    else $error("first set start edge did not hold");
  a_range_cfg: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cfg_take_reg |-> cfg_out.range_hi == $past(sc_reg[1]))
    else $error("range setting does not follow pin");
  a_ref_cfg: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cfg_take_reg |-> reference_io_pin_oe_b_out == !cfg_out.int_ref_en)
    else $error("reference drive does not follow selection");
  a_lsb_step: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cfg_take_reg |=> lsb_uv_out == ($past(cfg_out.range_hi) ? 16'h0131 : 16'h0098))
    else $error("lsb weight does not match range");
  a_mem_idle: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    busy_out |-> !commit_reg || ch_reg == 3'h0)
    else $error("result commit overlaps a channel write");
endmodule

// *** verif/ssc_host_model.sv ***
`timescale 1ns/1ns
module ssc_host_model #(
  parameter int unsigned SETTLE = 2000 // 80 us at 25 MHz
) (
  input  wire logic clock_in,     // clock
  input  wire logic rst_b_in,     // async reset, low active
  input  wire logic range_pin_in, // range pin level
  input  wire logic go_a_in,      // request first set start
  input  wire logic go_b_in,      // request second set start
  output logic      start_a_out,  // first set start pin
  output logic      start_b_out,  // second set start pin
  output logic      settled_out   // range settled, starts allowed
);
  logic [11:0] settle_reg;
  logic        range_reg;
  assign settled_out = (settle_reg >= 12'(SETTLE));
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      settle_reg <= 12'h000;
      range_reg <= 1'b0;
      start_a_out <= 1'b0;
      start_b_out <= 1'b0;
    end else begin
      range_reg <= range_pin_in;
      if (range_reg != range_pin_in)
        settle_reg <= 12'h000;
      else if (!settled_out)
        settle_reg <= settle_reg + 12'h001;
      start_a_out <= go_a_in && settled_out;
      start_b_out <= go_b_in && settled_out;
    end
  end
endmodule

// *** verif/ssc_conv_ctrl_bench.sv ***
`timescale 1ns/1ns
module ssc_conv_ctrl_bench;
  import ssc_pkg::*;
  logic        clock_in, rst_b_in, range_pin, ref_sel, go_a, go_b;
  logic        pin_a, pin_b, settled, busy, oe_b;
  logic [15:0] sample, rd_data, lsb_uv;
  logic [2:0]  rd_addr;
  logic [1:0]  hold;
  logic [2:0]  conv_ch;
  ssc_cfg_s    cfg;
  int          n_fail, samples_checked, cyc, n;
  ssc_host_model u_host (.clock_in(clock_in), .rst_b_in(rst_b_in), .range_pin_in(range_pin),
    .go_a_in(go_a), .go_b_in(go_b), .start_a_out(pin_a), .start_b_out(pin_b),
    .settled_out(settled));
  ssc_conv_ctrl #(.CHANNELS(8)) u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .first_set_start_pulse_in(pin_a), .second_set_start_pulse_in(pin_b),
    .range_pin_in(range_pin), .ref_select_in(ref_sel), .sample_in(sample),
    .rd_addr_in(rd_addr), .rd_data_out(rd_data), .busy_out(busy), .hold_out(hold),
    .conv_ch_out(conv_ch), .cfg_out(cfg), .reference_io_pin_oe_b_out(oe_b), .lsb_uv_out(lsb_uv));
  task results;
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 400) begin
      @(negedge clock_in);
      k++;
    end
    chk(16'(busy), 16'(lvl), "busy wait");
  endtask
  task start(input logic a, input logic b);
    int k;
    k = 0;
    while (settled !== 1'b1 && k < 3000) begin
      @(negedge clock_in);
      k++;
    end
    @(posedge clock_in);
    go_a <= a;
    go_b <= b;
    @(posedge clock_in);
    go_a <= 1'b0;
    go_b <= 1'b0;
  endtask
  task t_cfg;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_in);
      range_pin <= i[0];
      ref_sel <= i[1];
      repeat (5) @(negedge clock_in);
      chk(16'(cfg), {14'h0000, i[0], i[1]}, "cfg");
      chk(lsb_uv, 16'((i[0] ? SPAN_HI_MV : SPAN_LO_MV) * 1000 / LSB_DIV), "lsb");
      chk(16'(oe_b), 16'(!i[1]), "ref drive");
    end
  endtask
  task t_conv(input logic [15:0] code, input logic [15:0] prev, input logic old);
    @(posedge clock_in);
    sample <= code;
    rd_addr <= 3'h5;
    start(1'b1, 1'b1);
    wait_busy(1'b1);
    chk(16'(hold), 16'h0003, "hold both");
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      @(negedge clock_in);
      n++;
      if (n == 50 && old) chk(rd_data, prev, "old result");
      if (n == 50) chk(16'(hold), 16'h0003, "hold kept");
      if (n == 1) chk(16'(conv_ch), 16'h0000, "first channel");
      if (n == 99) chk(16'(conv_ch), 16'h0007, "last channel");
    end
    chk(16'(n), 16'(CONV_NS_8CH * CLK_MHZ / 1000), "conv time");
    chk(16'(hold), 16'h0000, "track");
    repeat (12) @(negedge clock_in);
    for (int c = 0; c < 8; c++) begin
      @(posedge clock_in);
      rd_addr <= 3'(c);
      repeat (2) @(negedge clock_in);
      chk(rd_data, code, "result");
    end
  endtask
  task t_split;
    start(1'b1, 1'b0);
    repeat (10) @(negedge clock_in);
    chk(16'(hold), 16'h0001, "first set hold");
    chk(16'(busy), 16'h0000, "busy early");
    start(1'b0, 1'b1);
    wait_busy(1'b1);
    chk(16'(hold), 16'h0003, "both held");
    wait_busy(1'b0);
  endtask
  task t_abort;
    start(1'b1, 1'b1);
    wait_busy(1'b1);
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b0;
    @(negedge clock_in);
    chk({15'h0000, busy}, 16'h0000, "abort busy");
    chk(16'(hold), 16'h0000, "abort hold");
    @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (5) @(negedge clock_in);
    chk(16'(cfg), {14'h0000, range_pin, ref_sel}, "cfg after reset");
  endtask
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    rst_b_in = 1'b0;
    range_pin = 1'b1;
    ref_sel = 1'b1;
    go_a = 1'b0;
    go_b = 1'b0;
    sample = 16'h0000;
    rd_addr = 3'h0;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_cfg();
    t_conv(16'h8000, 16'h0000, 1'b0);
    t_conv(16'h7fff, 16'h8000, 1'b1);
    t_split();
    t_abort();
    results();
  end
endmodule
